//--- msd_consts.svh
// constants for the move, special read and coprocessor read decoder
`ifndef MSD_CONSTS_SVH
`define MSD_CONSTS_SVH
`define MSD_REG_SP 4'hd
`define MSD_REG_PC 4'hf
`define MSD_SEL_FLAGS 8'h00
`define MSD_SEL_CONTROL 8'h14
`define MSD_HI_MOVE_TOP_HALFWORD 11'h7ac
`define MSD_HI_MRC 8'hfd
`define MSD_HI_COPROC_READ_DOUBLE 11'h7c5
`define MSD_HI_MRS 11'h79f
`define MSD_HI_MOVSH 15'h752f
`define MSD_HI_SHREG 17'h1_f4f0
`endif

//--- msd_pkg.sv
// types for the move, special read and coprocessor read decoder
package msd_pkg;
  typedef enum logic [2:0] {
    MSD_IDLE,
    MSD_CP_WAIT,
    MSD_DONE
  } msd_state_t;
  typedef enum logic [2:0] {
    MSD_SH_LSL,
    MSD_SH_LSR,
    MSD_SH_ASR,
    MSD_SH_ROR,
    MSD_SH_RRX
  } msd_shift_t;
endpackage

//--- msd_decode.sv
// decode and execute of move-top, shift alias, coproc and special reads
//Contract
// - move with shift executes as the matching shift or rotate instruction
// - move-top writes immediate to bits 31:16, keeps bits 15:0
// - move-top immediate is imm4, i, imm3, imm8 concatenated
// - move-top to register 13 or 15 is unpredictable
// - rejected coprocessor read raises usage fault, no register transfer
// - single read takes one 32-bit word from the coprocessor
// - single read writes whole word to r0-r14; r13 unpredictable
// - single read with dest all ones copies bits 31:28 to nzcv
// - one encoding bit selects alternate or basic coprocessor read
// - four-bit coprocessor number is presented with the instruction
// - single read has two three-bit opcodes, omitted second is zero
// - double read has a four-bit opcode field
// - double read writes first word to first dest, second to second
// - double read with r15 either dest or equal dests unpredictable
// - double read with r13 either dest unpredictable
// - failing condition leaves registers, flags, coprocessor untouched
// - special read copies selected special register to destination
// - special read privileged except selectors 0 and 0x14
`timescale 1ns/10ps
`include "msd_consts.svh"
module msd_decode
  import msd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // instruction issue
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic cond_pass,
  input wire logic privileged,
  output logic instr_ready,
  // register operands and flags
  input wire logic [31:0] dest_old_value,
  input wire logic [31:0] shift_src_value,
  input wire logic [7:0] shift_amt_value,
  input wire logic [3:0] flags_in,
  // special register read port
  output logic [7:0] special_selector,
  input wire logic [31:0] special_value,
  // coprocessor interface
  output logic cp_req,
  output logic [3:0] cp_num,
  output logic cp_alt,
  output logic cp_double,
  output logic [3:0] cp_opcode_a,
  output logic [2:0] cp_opcode_b,
  output logic [3:0] cp_reg_first,
  output logic [3:0] cp_reg_extra,
  input wire logic cp_resp,
  input wire logic cp_accept,
  input wire logic [31:0] cp_data_first,
  input wire logic [31:0] cp_data_second,
  // results
  output logic wr_en,
  output logic [3:0] wr_addr,
  output logic [31:0] wr_data,
  output logic wr2_en,
  output logic [3:0] wr2_addr,
  output logic [31:0] wr2_data,
  output logic flags_wr_en,
  output logic [3:0] flags_out,
  output logic usage_fault_exception,
  output logic privilege_fault,
  output logic unpredictable,
  output logic undefined_instr
);

  // ****************************************************************
  // reset release
  // ****************************************************************
  logic rst_meta_ff;
  logic rst_sync_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  // rest of the design resets from the synchronised copy
  wire logic srst_n = rst_sync_ff;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic is_sp_pc(input logic [3:0] r);
    return (r == `MSD_REG_SP) || (r == `MSD_REG_PC);
  endfunction

  function automatic logic [32:0] do_shift(input msd_shift_t t,
      input logic [31:0] v, input logic [7:0] n, input logic c);
    logic [63:0] w;
    logic [4:0] k;
    w = 64'h0000_0000_0000_0000;
    k = n[4:0];
    do_shift = {c, v};
    case (t)
      MSD_SH_LSL: begin
        if (n >= 8'h21) do_shift = 33'h0_0000_0000;
        else if (n != 8'h00) begin
          w = {32'h0000_0000, v} << n;
          do_shift = {w[32], w[31:0]};
        end
      end
      MSD_SH_LSR: begin
        if (n >= 8'h21) do_shift = 33'h0_0000_0000;
        else if (n != 8'h00) begin
          w = {v, 32'h0000_0000} >> n;
          do_shift = {w[31], w[63:32]};
        end
      end
      MSD_SH_ASR: begin
        if (n >= 8'h20) do_shift = {v[31], {32{v[31]}}};
        else if (n != 8'h00) begin
          w = {{32{v[31]}}, v} >> n;
          do_shift = {v[k - 5'd1], w[31:0]};
        end
      end
      MSD_SH_ROR: begin
        if (n != 8'h00) begin
          w = {v, v} >> k;
          do_shift = {w[31], w[31:0]};
        end
      end
      MSD_SH_RRX: do_shift = {v[0], c, v[31:1]};
      default: do_shift = {c, v};
    endcase
  endfunction

  // ****************************************************************
  // field decode
  // ****************************************************************
  logic [15:0] hw1;
  logic [15:0] hw2;
  assign hw1 = instr[31:16];
  assign hw2 = instr[15:0];

  // ****************************************************************
  // instruction classes
  // ****************************************************************

  logic is_move_top_halfword;
  logic is_mrc;
  logic is_coproc_read_double;
  logic is_mrs;
  logic is_movsh_imm;
  logic is_movsh_reg;
  assign is_move_top_halfword = {hw1[15:11], hw1[9:4]} == `MSD_HI_MOVE_TOP_HALFWORD
                   && !hw2[15];
  assign is_mrc = {hw1[15:13], hw1[11:8], hw1[4]} == `MSD_HI_MRC
                  && hw2[4];
  assign is_coproc_read_double = {hw1[15:13], hw1[11:4]} == `MSD_HI_COPROC_READ_DOUBLE;
  assign is_mrs = hw1[15:5] == `MSD_HI_MRS && hw2[15:14] == 2'h2;
  assign is_movsh_imm = {hw1[15:5], hw1[3:0]} == `MSD_HI_MOVSH
                        && !hw2[15];
  assign is_movsh_reg = {hw1[15:7], hw2[15:12], hw2[7:4]} ==
                        `MSD_HI_SHREG;

  logic [15:0] halfword_immediate;
  assign halfword_immediate = {hw1[3:0], hw1[10], hw2[14:12],
                               hw2[7:0]};

  logic [3:0] transfer_dest_first;
  logic [3:0] transfer_dest_second;
  logic [3:0] mov_dest;
  assign transfer_dest_first = hw2[15:12];
  assign transfer_dest_second = hw1[3:0];
  assign mov_dest = hw2[11:8];

  msd_shift_t sh_type;
  logic [7:0] sh_amt;
  always_comb begin
    sh_type = MSD_SH_LSL;
    sh_amt = shift_amt_value;
    if (is_movsh_imm) begin
      sh_amt = {3'h0, hw2[14:12], hw2[7:6]};
      case (hw2[5:4])
        2'h0: sh_type = MSD_SH_LSL;
        2'h1: sh_type = MSD_SH_LSR;
        2'h2: sh_type = MSD_SH_ASR;
        default: sh_type = (sh_amt == 8'h00) ? MSD_SH_RRX : MSD_SH_ROR;
      endcase
      if ((hw2[5:4] == 2'h1 || hw2[5:4] == 2'h2) && sh_amt == 8'h00)
        sh_amt = 8'h20;
    end else begin
      case (hw1[6:5])
        2'h0: sh_type = MSD_SH_LSL;
        2'h1: sh_type = MSD_SH_LSR;
        2'h2: sh_type = MSD_SH_ASR;
        default: sh_type = MSD_SH_ROR;
      endcase
    end
  end

  logic [32:0] sh_res;
  assign sh_res = do_shift(sh_type, shift_src_value, sh_amt,
                           flags_in[1]);

  // ****************************************************************
  // control sequence
  // ****************************************************************
  msd_state_t state_ff;
  logic accept_now;
  assign instr_ready = (state_ff == MSD_IDLE);
  assign accept_now = instr_valid && instr_ready;
  // coprocessor read taken with a passing condition
  logic cp_start;
  assign cp_start = accept_now && cond_pass && (is_mrc || is_coproc_read_double);

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) state_ff <= MSD_IDLE;
    else begin
      case (state_ff)
        MSD_IDLE:
          if (cp_start)
            state_ff <= MSD_CP_WAIT;
        MSD_CP_WAIT: if (cp_resp) state_ff <= MSD_IDLE;
        default: state_ff <= MSD_IDLE;
      endcase
    end
  end

  // coprocessor request fields held for the whole wait
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      cp_num <= 4'h0;
      cp_alt <= 1'b0;
      cp_double <= 1'b0;
      cp_opcode_a <= 4'h0;
      cp_opcode_b <= 3'h0;
      cp_reg_first <= 4'h0;
      cp_reg_extra <= 4'h0;
      wr2_addr <= 4'h0;
    end else if (cp_start) begin
      cp_num <= hw2[11:8];
      cp_alt <= hw1[12];
      cp_double <= is_coproc_read_double;
      cp_opcode_a <= is_coproc_read_double ? hw2[7:4] : {1'b0, hw1[7:5]};
      cp_opcode_b <= is_coproc_read_double ? 3'h0 : hw2[7:5];
      cp_reg_first <= is_coproc_read_double ? 4'h0 : hw1[3:0];
      cp_reg_extra <= hw2[3:0];
      wr2_addr <= transfer_dest_second;
    end
  end
  assign cp_req = (state_ff == MSD_CP_WAIT);

  // ****************************************************************
  // results
  // ****************************************************************
  logic [3:0] cp_dest_ff;
  // destination kept until the answer arrives
  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) cp_dest_ff <= 4'h0;
    else if (accept_now) cp_dest_ff <= transfer_dest_first;
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      wr_en <= 1'b0;
      wr_addr <= 4'h0;
      wr_data <= 32'h0000_0000;
      wr2_en <= 1'b0;
      wr2_data <= 32'h0000_0000;
      flags_wr_en <= 1'b0;
      flags_out <= 4'h0;
      usage_fault_exception <= 1'b0;
      privilege_fault <= 1'b0;
      unpredictable <= 1'b0;
      undefined_instr <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      wr2_en <= 1'b0;
      flags_wr_en <= 1'b0;
      usage_fault_exception <= 1'b0;
      privilege_fault <= 1'b0;
      unpredictable <= 1'b0;
      undefined_instr <= 1'b0;
      // coprocessor answer, issue is blocked meanwhile
      if (state_ff == MSD_CP_WAIT && cp_resp) begin
        if (!cp_accept) usage_fault_exception <= 1'b1;
        else if (cp_double) begin
          wr_en <= 1'b1;
          wr_addr <= cp_dest_ff;
          wr_data <= cp_data_first;
          wr2_en <= 1'b1;
          wr2_data <= cp_data_second;
        end else if (cp_dest_ff == `MSD_REG_PC) begin
          flags_wr_en <= 1'b1;
          flags_out <= cp_data_first[31:28];
        end else begin
          wr_en <= 1'b1;
          wr_addr <= cp_dest_ff;
          wr_data <= cp_data_first;
        end
      end else if (accept_now && cond_pass) begin
        if (is_move_top_halfword) begin
          wr_en <= 1'b1;
          wr_addr <= mov_dest;
          wr_data <= {halfword_immediate, dest_old_value[15:0]};
          unpredictable <= is_sp_pc(mov_dest);
        end else if (is_mrs) begin
          if (!privileged && hw2[7:0] != `MSD_SEL_FLAGS &&
              hw2[7:0] != `MSD_SEL_CONTROL)
            privilege_fault <= 1'b1;
          else begin
            wr_en <= 1'b1;
            wr_addr <= mov_dest;
            wr_data <= special_value;
          end
        end else if (is_movsh_imm || is_movsh_reg) begin
          wr_en <= 1'b1;
          wr_addr <= mov_dest;
          wr_data <= sh_res[31:0];
          if (hw1[4]) begin
            flags_wr_en <= 1'b1;
            flags_out <= {sh_res[31], sh_res[31:0] == 32'h0000_0000,
                          sh_res[32], flags_in[0]};
          end
        end else if (is_mrc) begin
          // transfer itself waits for the answer
          unpredictable <= transfer_dest_first == `MSD_REG_SP;
        end else if (is_coproc_read_double) begin
          unpredictable <= transfer_dest_first == `MSD_REG_PC ||
            transfer_dest_second == `MSD_REG_PC ||
            transfer_dest_first == transfer_dest_second ||
            transfer_dest_first == `MSD_REG_SP ||
            transfer_dest_second == `MSD_REG_SP;
        end else undefined_instr <= 1'b1;
      end
    end
  end

  assign special_selector = hw2[7:0];

endmodule // msd_decode

//--- msd_chk_monitor.sv
// assertion checker for the decoder ports
`timescale 1ns/10ps
module msd_chk (
  // clock, reset, issue
  input wire logic clk, rst_n, instr_valid, cond_pass, privileged,
  input wire logic instr_ready,
  input wire logic [31:0] instr, dest_old_value,
  // coprocessor side
  input wire logic cp_req, cp_double, cp_resp, cp_accept,
  input wire logic [3:0] cp_num,
  input wire logic [31:0] cp_data_first, cp_data_second,
  // results
  input wire logic wr_en, wr2_en, flags_wr_en,
  input wire logic usage_fault_exception, privilege_fault,
  input wire logic [31:0] wr_data, wr2_data,
  input wire logic [3:0] flags_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire tk = instr_valid && instr_ready;
  wire mvt = instr[31:27] == 5'h1e && instr[25:20] == 6'h2c && !instr[15];
  wire special_register_read = instr[31:12] == 20'hf_3ef8;
  wire [31:0] mv = {instr[19:16], instr[26], instr[14:12], instr[7:0],
    dest_old_value[15:0]};
  wire ans = cp_req && cp_resp;
  wire wany = wr_en || wr2_en || flags_wr_en;
  // ************
  // assertions
  // ************
  chk_move_top_halfword_half: assert property (
    tk && cond_pass && mvt |=> wr_en && wr_data == $past(mv))
    else $error("move-top result wrong");
  chk_priv_fault: assert property (
    tk && cond_pass && special_register_read && !privileged && instr[7:0] != 8'h00 &&
    instr[7:0] != 8'h14 |=> privilege_fault && !wr_en)
    else $error("unprivileged special read not refused");
  chk_cond_fail: assert property (
    tk && !cond_pass |=> !wany && !cp_req)
    else $error("failed condition had an effect");
  chk_reject_fault: assert property (
    ans && !cp_accept |=> usage_fault_exception && !wany)
    else $error("rejection without usage fault");
  chk_wait_quiet: assert property (
    cp_req |-> !wany && !instr_ready)
    else $error("write or issue during coprocessor wait");
  chk_fields_hold: assert property (
    cp_req && !cp_resp |=> cp_req && $stable(cp_num) && $stable(cp_double))
    else $error("coprocessor fields moved");
  chk_single_data: assert property (
    ans && cp_accept && !cp_double |=> !wr2_en &&
    (!wr_en || wr_data == $past(cp_data_first)) &&
    (!flags_wr_en || flags_out == $past(cp_data_first[31:28])))
    else $error("single read data wrong");
  chk_double_pair: assert property (
    ans && cp_accept && cp_double |=> wr_en && wr2_en &&
    wr_data == $past(cp_data_first) && wr2_data == $past(cp_data_second))
    else $error("double read pairing wrong");
  cov_accept: cover property (ans && cp_accept);
  cov_reject: cover property (ans && !cp_accept);
  cov_move_top_halfword: cover property (tk && cond_pass && mvt);
endmodule // msd_chk
bind msd_decode msd_chk u_msd_chk (.clk, .rst_n, .instr_valid, .cond_pass,
  .privileged, .instr_ready, .instr, .dest_old_value, .cp_req, .cp_double,
  .cp_resp, .cp_accept, .cp_num, .cp_data_first, .cp_data_second, .wr_en,
  .wr2_en, .flags_wr_en, .usage_fault_exception, .privilege_fault,
  .wr_data, .wr2_data, .flags_out);

//--- msd_cp_model.sv
// attached coprocessor partner model
`timescale 1ns/10ps
module msd_cp_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // request and scenario control
  input wire logic cp_req,
  input wire logic [3:0] cp_num,
  input wire logic [15:0] accept_mask,
  input wire logic [3:0] delay,
  // answer
  output logic cp_resp,
  output logic cp_accept,
  output logic [31:0] cp_data_first,
  output logic [31:0] cp_data_second
);
  logic [3:0] cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      cp_resp <= 1'b0;
      cp_accept <= 1'b0;
      cp_data_first <= 32'h0000_0000;
      cp_data_second <= 32'h0000_0000;
    end else if (cp_req && !cp_resp && cnt_ff == delay) begin
      cnt_ff <= 4'h0;
      cp_resp <= 1'b1;
      cp_accept <= accept_mask[cp_num];
      cp_data_first <= 32'h1357_9bd0 | {28'h0, cp_num};
      cp_data_second <= 32'h2468_ace0 | {28'h0, cp_num};
    end else begin
      cnt_ff <= (cp_req && !cp_resp) ? cnt_ff + 4'h1 : 4'h0;
      cp_resp <= 1'b0;
      cp_accept <= ~cp_accept;
      cp_data_first <= ~cp_data_first;
      cp_data_second <= ~cp_data_second;
    end
  end
endmodule // msd_cp_model

//--- tb_top.sv
// self-checking bench for the decoder
`timescale 1ns/10ps
module tb_top;
  typedef struct {
    logic [31:0] in;
    logic pv;
    logic [31:0] exp;
    logic [3:0] ad;
    logic [2:0] fl;
  } msd_row_t;
  logic clk = 0, rst_n = 0, instr_valid = 0, cond_pass = 1, privileged = 0;
  logic [31:0] instr = 0, special_value, cp_data_first, cp_data_second;
  logic [31:0] wr_data, wr2_data;
  logic instr_ready, cp_req, cp_alt, cp_double, cp_resp, cp_accept, wr_en;
  logic wr2_en, flags_wr_en, usage_fault_exception, privilege_fault;
  logic unpredictable, undefined_instr;
  logic [7:0] special_selector;
  logic [3:0] cp_num, cp_opcode_a, cp_reg_first, cp_reg_extra, wr_addr;
  logic [3:0] wr2_addr, flags_out, delay;
  logic [2:0] cp_opcode_b;
  int fails = 0, check_count = 0, n;
  msd_row_t rows[11] = '{
    '{32'hea4f_1203, 0, 32'h7654_3210, 2, 3'b100},
    '{32'hea4f_2213, 0, 32'h0087_6543, 2, 3'b100},
    '{32'hea4f_1223, 0, 32'hf876_5432, 2, 3'b100},
    '{32'hea4f_1233, 0, 32'h1876_5432, 2, 3'b100},
    '{32'hea4f_0233, 0, 32'hc3b2_a190, 2, 3'b100},
    '{32'hfa01_f203, 0, 32'h6543_2100, 2, 3'b100},
    '{32'hf6ca_35cd, 0, 32'habcd_2222, 5, 3'b100},
    '{32'hf2c0_0d00, 0, 32'h0000_2222, 13, 3'b110},
    '{32'hf3ef_8400, 0, 32'h5a5a_5000, 4, 3'b100},
    '{32'hf3ef_8414, 0, 32'h5a5a_5014, 4, 3'b100},
    '{32'hf3ef_8408, 1, 32'h5a5a_5008, 4, 3'b100}};
  always #5 clk = ~clk;
  assign special_value = {24'h5a_5a50, special_selector};
  assign delay = {2'b00, cp_num[1:0]};
  msd_decode u_msd_decode (.clk, .rst_n, .instr_valid, .instr, .cond_pass,
    .privileged, .instr_ready, .dest_old_value(32'h1111_2222),
    .shift_src_value(32'h8765_4321), .shift_amt_value(8'h08),
    .flags_in(4'h2), .special_selector, .special_value, .cp_req, .cp_num,
    .cp_alt, .cp_double, .cp_opcode_a, .cp_opcode_b, .cp_reg_first,
    .cp_reg_extra, .cp_resp, .cp_accept, .cp_data_first, .cp_data_second,
    .wr_en, .wr_addr, .wr_data, .wr2_en, .wr2_addr, .wr2_data, .flags_wr_en,
    .flags_out, .usage_fault_exception, .privilege_fault, .unpredictable,
    .undefined_instr);
  msd_cp_model u_msd_cp_model (.clk, .rst_n, .cp_req, .cp_num,
    .accept_mask(16'hfeff), .delay, .cp_resp, .cp_accept, .cp_data_first,
    .cp_data_second);
  task chk(input logic [63:0] g, input logic [63:0] e);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task issue(input logic [31:0] ins, input logic pv, input logic c);
    @(posedge clk);
    instr <= ins;
    privileged <= pv;
    cond_pass <= c;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask
  task cp_run(input logic [31:0] ins, input logic [20:0] f);
    logic [20:0] got;
    issue(ins, 1'b1, 1'b1);
    chk(instr_ready, 1'b0);
    got = {cp_num, cp_alt, cp_double, cp_opcode_a, cp_reg_first,
      cp_reg_extra, cp_opcode_b & {3{!cp_double}}};
    chk(got, f);
    n = 0;
    while (cp_resp !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(n < 20, 1'b1);
    @(posedge clk);
    #1;
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({instr_ready, wr_en, cp_req}, 3'b100);
    foreach (rows[i]) begin
      issue(rows[i].in, rows[i].pv, 1'b1);
      chk(wr_en, rows[i].fl[2]);
      chk(wr_data, rows[i].exp);
      chk(wr_addr, rows[i].ad);
      chk(unpredictable, rows[i].fl[1]);
      chk(privilege_fault, rows[i].fl[0]);
    end
    issue(32'hea5f_0233, 1'b1, 1'b1);
    chk({flags_wr_en, flags_out, wr_data}, {1'b1, 4'ha, 32'hc3b2_a190});
    issue(32'hf3ef_8408, 1'b0, 1'b1);
    chk({wr_en, privilege_fault}, 2'b01);
    issue(32'hf6ca_35cd, 1'b0, 1'b0);
    chk({wr_en, undefined_instr, flags_wr_en}, 3'b000);
    issue(32'heef3_49f2, 1'b1, 1'b0);
    @(posedge clk);
    #1;
    chk(cp_req, 1'b0);
    cp_run(32'heef3_49f2, {4'h9, 2'b00, 4'h7, 4'h3, 4'h2, 3'h7});
    chk({wr_en, wr_addr, wr_data}, {1'b1, 4'h4, 32'h1357_9bd9});
    cp_run(32'hfe10_f210, {4'h2, 2'b10, 4'h0, 4'h0, 4'h0, 3'h0});
    chk({flags_wr_en, flags_out, wr_en}, {1'b1, 4'h1, 1'b0});
    cp_run(32'hec57_63f1, {4'h3, 2'b01, 4'hf, 4'h0, 4'h1, 3'h0});
    chk({wr_en, wr_addr, wr_data}, {1'b1, 4'h6, 32'h1357_9bd3});
    chk({wr2_en, wr2_addr, wr2_data}, {1'b1, 4'h7, 32'h2468_ace3});
    cp_run(32'heef3_48f2, {4'h8, 2'b00, 4'h7, 4'h3, 4'h2, 3'h7});
    chk({usage_fault_exception, wr_en, flags_wr_en}, 3'b100);
    repeat (3) @(posedge clk);
    end_sim;
  end
endmodule // tb_top
